// ---- core/branch_cache_tuning_lock.sv ----
// Purpose: tuning, slot locking and miss penalty counting for the branch target cache, plus flash busy
// Assumes: all inputs come from logic on sys_clk_in; registers sit on the special-function register port
// Notes:   the cache array itself lives outside; this block tells it where and whether to write
//
// What this block does
// - tuning policy bit 0 selects rebound replacement, 1 selects pseudo-random
// - force bit set puts table-read fill data in slot 0, else policy decides
// - miss data cached only when its stall exceeded the two-bit threshold; a pushed table read is written whatever its stall
// - push enabled: each table read locks its 4-byte segment at pointer, then decrements
// - pointer zero means every slot is unlocked
// - writing one to pop increments pointer, unlocking that slot; pop reads zero
// - pointer is read-only; slots above it are locked unless pointer is zero
// - overflow flag sets on accumulator overflow, holds until accumulator written
// - accumulator counts stall cycles; bits 11-5 readable in low seven bits
// - writing the high accumulator field clears accumulator bits 4-0
// - reading high field returns it and latches bits 4-1 into tuning upper nibble
// - accumulator bit 0 unreadable; total penalty is twice the high:low value
// - flash status bit 0 reads one during flash write or erase
// - rebound sweeps first to last slot, then last back to first
// - flash write or erase always invalidates the affected cache bytes
`timescale 1ns/1ps
`include "branch_cache_regs.svh"

module branch_cache_tuning_lock (
  // clock and reset
  input  wire logic                           sys_clk_in,
  input  wire logic                           rst_n_in,
  // special-function register port
  input  wire logic [7:0]                     sfr_addr_in,
  input  wire logic                           sfr_wr_in,
  input  wire logic                           sfr_rd_in,
  input  wire logic [7:0]                     sfr_wdata_in,
  output logic [7:0]                          sfr_rdata_out,
  // core fetch path
  input  wire logic                           miss_stall_in,
  input  wire branch_cache_pkg::fetch_done_t  fetch_in,
  // flash controller
  input  wire logic                           flash_busy_in,
  input  wire logic                           flash_modify_in,
  input  wire logic [15:0]                    flash_addr_in,
  // cache array
  output branch_cache_pkg::cache_wr_t         cache_wr_out,
  output logic                                flash_inval_out,
  output logic [15:0]                         flash_inval_addr_out,
  output logic [5:0]                          lock_slot_pointer_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [3:0]  tuning_low;
  logic [3:0]  penalty_count_low;
  logic        lock_push_enable;
  logic [5:0]  lock_slot_pointer;
  logic [11:0] penalty_acc;
  logic        penalty_overflow_flag;
  logic [7:0]  stall_len;
  logic [5:0]  victim;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire sel_flash  = (sfr_addr_in == `FLASH_STATUS_ADDR);
  wire sel_acc    = (sfr_addr_in == `CACHE_MISS_ACC_ADDR);
  wire sel_tuning = (sfr_addr_in == `CACHE_TUNING_ADDR);
  wire sel_lock   = (sfr_addr_in == `CACHE_LOCK_CTRL_ADDR);

  wire wr_acc    = sfr_wr_in && sel_acc;
  wire rd_acc    = sfr_rd_in && sel_acc;
  wire wr_tuning = sfr_wr_in && sel_tuning;
  wire wr_lock   = sfr_wr_in && sel_lock;
  wire pop_req   = wr_lock && sfr_wdata_in[`LOCK_POP_BIT];

  wire branch_cache_pkg::replace_policy_t policy =
    branch_cache_pkg::replace_policy_t'(tuning_low[`TUNING_POLICY_BIT]);
  wire table_read_slot_zero_force = tuning_low[`TUNING_FORCE_BIT];
  wire [1:0] miss_threshold       = tuning_low[1:0];

  // ----------------------------------------------------------------
  // fill decisions
  // ----------------------------------------------------------------
  // pointer zero drops every lock, so the whole cache becomes replaceable
  wire        all_unlocked = (lock_slot_pointer == 6'h00);
  wire [5:0]  replace_limit = all_unlocked ? `SLOT_MAX : lock_slot_pointer;

  wire push_op   = fetch_in.done && fetch_in.table_read && lock_push_enable;
  // stall_len counts this fetch's stall cycles up to completion
  // one bit wider so a saturated count plus this cycle cannot wrap to zero
  wire [8:0] stall_total = {1'b0, stall_len} + {8'h00, miss_stall_in};
  wire over_thr  = stall_total > {7'h00, miss_threshold};
  wire fill_op   = fetch_in.done && !push_op && over_thr;
  wire force_z   = fill_op && fetch_in.table_read && table_read_slot_zero_force;
  wire advance   = fill_op && !force_z;

  wire [5:0] fill_slot = force_z ? 6'h00 : victim;

  wire branch_cache_pkg::cache_wr_t next_cache_wr = '{
    write: push_op || fill_op,
    lock:  push_op,
    slot:  push_op ? lock_slot_pointer : fill_slot
  };

  // pop after push in the same cycle nets out to no move
  wire [5:0] next_lock_slot_pointer =
    lock_slot_pointer - {5'h00, push_op} + {5'h00, pop_req};

  // ----------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------
  // a write clears the five hidden bits; a stall in the same cycle still counts
  wire [11:0] acc_base = wr_acc ? {sfr_wdata_in[6:0], 5'h00} : penalty_acc;
  wire [12:0] acc_sum  = {1'b0, acc_base} + {12'h000, miss_stall_in};
  wire        next_overflow = acc_sum[12] || (!wr_acc && penalty_overflow_flag);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [7:0] rd_flash  = {7'h00, flash_busy_in};
  wire [7:0] rd_acc_v  = {penalty_overflow_flag, penalty_acc[11:5]};
  wire [7:0] rd_tuning = {penalty_count_low, tuning_low};
  wire [7:0] rd_lock   = {lock_push_enable, 1'b0, lock_slot_pointer};
  wire [7:0] next_rdata = sel_flash  ? rd_flash  :
                          sel_acc    ? rd_acc_v  :
                          sel_tuning ? rd_tuning :
                          sel_lock   ? rd_lock   : 8'h00;

  // ----------------------------------------------------------------
  // replacement
  // ----------------------------------------------------------------
  slot_replace_select u_select (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .policy_in  (policy),
    .limit_in   (replace_limit),
    .advance_in (advance),
    .slot_out   (victim)
  );

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tuning_low <= `TUNING_LOW_RESET;
    end else if (wr_tuning) begin
      tuning_low <= sfr_wdata_in[3:0];
    end
  end

  // upper nibble only moves on a read of the high field, so both halves match
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      penalty_count_low <= 4'h0;
    end else if (rd_acc) begin
      penalty_count_low <= penalty_acc[4:1];
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lock_push_enable  <= 1'b0;
      lock_slot_pointer <= `LOCK_PTR_RESET;
    end else begin
      if (wr_lock) begin
        lock_push_enable <= sfr_wdata_in[`LOCK_PUSH_BIT];
      end
      lock_slot_pointer <= next_lock_slot_pointer;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      penalty_acc           <= 12'h000;
      penalty_overflow_flag <= 1'b0;
    end else begin
      penalty_acc           <= acc_sum[11:0];
      penalty_overflow_flag <= next_overflow;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stall_len <= 8'h00;
    end else if (fetch_in.done) begin
      stall_len <= 8'h00;
    end else if (miss_stall_in && stall_len != 8'hff) begin
      stall_len <= stall_len + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sfr_rdata_out         <= 8'h00;
      cache_wr_out          <= '0;
      flash_inval_out       <= 1'b0;
      flash_inval_addr_out  <= 16'h0000;
      lock_slot_pointer_out <= `LOCK_PTR_RESET;
    end else begin
      if (sfr_rd_in) begin
        sfr_rdata_out <= next_rdata;
      end
      cache_wr_out          <= next_cache_wr;
      // independent of any cache write enable elsewhere
      flash_inval_out       <= flash_modify_in;
      flash_inval_addr_out  <= flash_addr_in;
      lock_slot_pointer_out <= next_lock_slot_pointer;
    end
  end

endmodule

// ---- core/branch_cache_regs.svh ----
// Purpose: register offsets, field positions, reset values for the branch cache tuning and lock block
// Assumes: 8-bit special-function register space
// Notes:   definitions only
`ifndef BRANCH_CACHE_REGS_SVH
`define BRANCH_CACHE_REGS_SVH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define FLASH_STATUS_ADDR        8'h88
`define CACHE_MISS_ACC_ADDR      8'h9a
`define CACHE_TUNING_ADDR        8'ha2
`define CACHE_LOCK_CTRL_ADDR     8'ha3

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define TUNING_POLICY_BIT        3
`define TUNING_FORCE_BIT         2
`define LOCK_PUSH_BIT            7
`define LOCK_POP_BIT             6
`define ACC_OVF_BIT              7
`define FLASH_BUSY_BIT           0
`define TUNING_LOW_RESET         4'h4
`define LOCK_PTR_RESET           6'h3f
`define SLOT_MAX                 6'h3f
`define LFSR_SEED                8'h01

`endif

// ---- core/branch_cache_pkg.sv ----
// Purpose: shared types of the branch cache tuning and lock block
// Assumes: constants live in branch_cache_regs.svh
// Notes:   no constants here
package branch_cache_pkg;

  typedef enum logic {POLICY_REBOUND, POLICY_RANDOM} replace_policy_t;

  typedef enum logic {DIR_UP, DIR_DOWN} sweep_dir_t;

  // one request to the cache array to fill a slot
  typedef struct packed {
    logic       write;
    logic       lock;
    logic [5:0] slot;
  } cache_wr_t;

  // one completed fetch from the core
  typedef struct packed {
    logic       done;
    logic       table_read;
  } fetch_done_t;

endpackage

// ---- core/slot_replace_select.sv ----
// Purpose: picks the next victim slot among unlocked slots
// Assumes: limit is the highest replaceable slot
// Notes:   the rebound sweep advances only when a normal fill uses the pick
`timescale 1ns/1ps
`include "branch_cache_regs.svh"

module slot_replace_select (
  // clock and reset
  input  wire logic                            sys_clk_in,
  input  wire logic                            rst_n_in,
  // control
  input  wire branch_cache_pkg::replace_policy_t policy_in,
  input  wire logic [5:0]                      limit_in,
  input  wire logic                            advance_in,
  // pick
  output logic [5:0]                           slot_out
);

  logic [7:0]                   lfsr;
  logic [5:0]                   pos;
  branch_cache_pkg::sweep_dir_t dir;
  wire  [6:0]                   span      = {1'b0, limit_in} + 7'h01;
  wire  [6:0]                   rnd_pick  = {1'b0, lfsr[5:0]} % span;
  wire  [5:0]                   pos_clamp = (pos > limit_in) ? limit_in : pos;
  wire                          lfsr_fb   = lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3];

  // ----------------------------------------------------------------
  // selection
  // ----------------------------------------------------------------
  // modulo keeps the random pick below the lock boundary
  assign slot_out = (policy_in == branch_cache_pkg::POLICY_RANDOM) ? rnd_pick[5:0] : pos_clamp;

  // free running so the pick does not repeat with the fill pattern
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lfsr <= `LFSR_SEED;
    end else begin
      lfsr <= {lfsr[6:0], lfsr_fb};
    end
  end

  // ----------------------------------------------------------------
  // rebound sweep
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pos <= 6'h00;
      dir <= branch_cache_pkg::DIR_UP;
    end else if (advance_in && policy_in == branch_cache_pkg::POLICY_REBOUND) begin
      case (dir)
        branch_cache_pkg::DIR_UP: begin
          if (pos_clamp >= limit_in) begin
            dir <= branch_cache_pkg::DIR_DOWN;
            pos <= (pos_clamp == 6'h00) ? 6'h00 : pos_clamp - 6'h01;
          end else begin
            pos <= pos_clamp + 6'h01;
          end
        end
        branch_cache_pkg::DIR_DOWN: begin
          if (pos_clamp == 6'h00) begin
            dir <= branch_cache_pkg::DIR_UP;
            pos <= (limit_in == 6'h00) ? 6'h00 : 6'h01;
          end else begin
            pos <= pos_clamp - 6'h01;
          end
        end
        default: begin
          dir <= branch_cache_pkg::DIR_UP;
        end
      endcase
    end
  end

endmodule

// ---- verif/fetch_core_model.sv ----
// Purpose: core fetch engine model: one fetch with a chosen stall length
// Assumes: the bench gives start_in for one cycle while the model is idle
// Notes:   stall length zero gives a done pulse with no stall
`timescale 1ns/1ps

module fetch_core_model (
  // clock and reset
  input  wire logic                          sys_clk_in,
  input  wire logic                          rst_n_in,
  // command from the bench
  input  wire logic                          start_in,
  input  wire logic [7:0]                    stall_len_in,
  input  wire logic                          table_read_in,
  // toward the block
  output logic                               miss_stall_out,
  output branch_cache_pkg::fetch_done_t      fetch_out
);
  logic [7:0] cnt;
  logic       act;
  logic       tr;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      act <= 1'b0;
      cnt <= 8'h00;
      tr  <= 1'b0;
    end else if (start_in) begin
      act <= 1'b1;
      cnt <= stall_len_in;
      tr  <= table_read_in;
    end else if (act) begin
      if (cnt <= 8'h01) begin
        act <= 1'b0;
      end
      if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
    end
  end

  // stall stays high up to and including the done cycle
  assign miss_stall_out       = act && (cnt != 8'h00);
  assign fetch_out = '{done: act && (cnt <= 8'h01), table_read: act && tr};
endmodule

// ---- verif/branch_cache_tuning_lock_sva.sv ----
// Purpose: port-level properties of the branch cache tuning and lock block
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   read data reflects register state from before the read edge
`timescale 1ns/1ps
`include "branch_cache_regs.svh"

module branch_cache_tuning_lock_sva (
  // clock and reset
  input  wire logic                          sys_clk_in,
  input  wire logic                          rst_n_in,
  // register port
  input  wire logic [7:0]                    sfr_addr_in,
  input  wire logic                          sfr_wr_in,
  input  wire logic                          sfr_rd_in,
  input  wire logic [7:0]                    sfr_wdata_in,
  input  wire logic [7:0]                    sfr_rdata_out,
  // fetch path and flash
  input  wire logic                          miss_stall_in,
  input  wire branch_cache_pkg::fetch_done_t fetch_in,
  input  wire logic                          flash_busy_in,
  input  wire logic                          flash_modify_in,
  input  wire logic [15:0]                   flash_addr_in,
  // cache array side
  input  wire branch_cache_pkg::cache_wr_t   cache_wr_out,
  input  wire logic                          flash_inval_out,
  input  wire logic [15:0]                   flash_inval_addr_out,
  input  wire logic [5:0]                    lock_slot_pointer_out
);
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  wire lock_wr = sfr_wr_in && (sfr_addr_in == `CACHE_LOCK_CTRL_ADDR);
  wire lock_rd = sfr_rd_in && (sfr_addr_in == `CACHE_LOCK_CTRL_ADDR);

  a_lock_readback: assert property (lock_rd |=>
    sfr_rdata_out[6] == 1'b0 && sfr_rdata_out[5:0] == $past(lock_slot_pointer_out)) else $error("lock readback wrong");
  a_busy_readback: assert property (sfr_rd_in && sfr_addr_in == `FLASH_STATUS_ADDR |=>
    sfr_rdata_out == {7'h00, $past(flash_busy_in)}) else $error("flash status readback wrong");
  a_inval_follows: assert property (flash_modify_in |=>
    flash_inval_out && flash_inval_addr_out == $past(flash_addr_in)) else $error("flash invalidate missing");
  a_fill_after_done: assert property (cache_wr_out.write |-> $past(fetch_in.done))
    else $error("fill without completed fetch");
  a_push_slot: assert property (cache_wr_out.write && cache_wr_out.lock |->
    cache_wr_out.slot == $past(lock_slot_pointer_out)) else $error("push slot not pointer");
  a_push_decrement: assert property (cache_wr_out.lock && !$past(lock_wr && sfr_wdata_in[6]) |->
    lock_slot_pointer_out == $past(lock_slot_pointer_out) - 6'h01) else $error("push did not decrement");
  a_pop_increment: assert property (lock_wr && sfr_wdata_in[6] && !fetch_in.done |=>
    lock_slot_pointer_out == $past(lock_slot_pointer_out) + 6'h01) else $error("pop did not increment");
  a_ptr_read_only: assert property (lock_wr && !sfr_wdata_in[6] && !fetch_in.done |=>
    $stable(lock_slot_pointer_out)) else $error("pointer changed by write");
  a_victim_unlocked: assert property (cache_wr_out.write && !cache_wr_out.lock &&
    $past(lock_slot_pointer_out) != 6'h00 |-> cache_wr_out.slot <= $past(lock_slot_pointer_out))
    else $error("locked slot replaced");
endmodule

bind branch_cache_tuning_lock branch_cache_tuning_lock_sva chk_u (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
  .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
  .miss_stall_in(miss_stall_in), .fetch_in(fetch_in), .flash_busy_in(flash_busy_in),
  .flash_modify_in(flash_modify_in), .flash_addr_in(flash_addr_in), .cache_wr_out(cache_wr_out),
  .flash_inval_out(flash_inval_out), .flash_inval_addr_out(flash_inval_addr_out),
  .lock_slot_pointer_out(lock_slot_pointer_out));

// ---- verif/testbench.sv ----
// Purpose: self-checking bench for the branch cache tuning and lock block
// Assumes: register strobes are one-cycle pulses, fills appear one edge after done
// Notes:   random victim values are not predicted, only their range
`timescale 1ns/1ps

module testbench;
  typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] data;} row_t;
  logic sys_clk_in, rst_n_in, sfr_wr_in, sfr_rd_in, flash_busy_in, flash_modify_in, f_start, f_tr, miss_stall;
  logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, f_len;
  logic [15:0] flash_addr_in, inval_addr;
  logic inval;
  logic [5:0] ptr, prev;
  branch_cache_pkg::fetch_done_t fetch;
  branch_cache_pkg::cache_wr_t   cwr, seen;
  int mismatches = 0;
  int num_checks = 0;
  row_t rows[11] = '{{1'b0, 8'h88, 8'h00}, {1'b0, 8'ha2, 8'h04}, {1'b0, 8'ha3, 8'h3f}, {1'b0, 8'h9a, 8'h00},
    {1'b0, 8'h55, 8'h00}, {1'b1, 8'h88, 8'hff}, {1'b0, 8'h88, 8'h00}, {1'b1, 8'ha3, 8'h3f},
    {1'b0, 8'ha3, 8'h3f}, {1'b1, 8'ha2, 8'hf3}, {1'b0, 8'ha2, 8'h03}};

  branch_cache_tuning_lock dut_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
    .miss_stall_in(miss_stall), .fetch_in(fetch), .flash_busy_in(flash_busy_in),
    .flash_modify_in(flash_modify_in), .flash_addr_in(flash_addr_in), .cache_wr_out(cwr),
    .flash_inval_out(inval), .flash_inval_addr_out(inval_addr), .lock_slot_pointer_out(ptr));
  fetch_core_model core_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .start_in(f_start),
    .stall_len_in(f_len), .table_read_in(f_tr), .miss_stall_out(miss_stall), .fetch_out(fetch));

  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  task automatic give_verdict;
    if (mismatches == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] got, input logic [15:0] expv);
    num_checks++;
    if (got !== expv) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, expv, got);
    end
  endtask

  task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    #1;
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = wr;
    sfr_rd_in = !wr;
    @(posedge sys_clk_in);
    #1;
    sfr_wr_in = 1'b0;
    sfr_rd_in = 1'b0;
    if (!wr) check("sfr read", {8'h00, sfr_rdata_out}, {8'h00, d});
  endtask

  // the fill, if any, is sampled one edge after the done cycle
  task automatic do_fetch(input logic [7:0] len, input logic tr);
    int i;
    @(posedge sys_clk_in);
    #1;
    f_len = len;
    f_tr = tr;
    f_start = 1'b1;
    @(posedge sys_clk_in);
    #1;
    f_start = 1'b0;
    for (i = 0; i < 64 && fetch.done !== 1'b1; i++) begin
      @(posedge sys_clk_in);
      #1;
    end
    if (i == 64) begin
      mismatches++;
      give_verdict();
    end
    @(posedge sys_clk_in);
    #1;
    seen = cwr;
  endtask

  initial begin
    {sfr_wr_in, sfr_rd_in, flash_busy_in, flash_modify_in, f_start, f_tr} = '0;
    {sfr_addr_in, sfr_wdata_in, f_len, flash_addr_in} = '0;
    rst_n_in = 1'b0;
    repeat (16) @(posedge sys_clk_in);
    #1;
    rst_n_in = 1'b1;
    foreach (rows[k]) sfr(rows[k].wr, rows[k].addr, rows[k].data);
    sfr(1'b1, 8'ha2, 8'h00);
    for (int i = 0; i < 64; i++) begin
      do_fetch(8'h01, 1'b0);
      check("rebound slot", {10'h000, seen.slot}, 16'(i));
    end
    do_fetch(8'h01, 1'b0);
    prev = seen.slot;
    do_fetch(8'h01, 1'b0);
    check("rebound turn", {15'h0000, seen.slot < prev}, 16'h0001);
    check("rebound first back", {10'h000, prev}, 16'h003e);
    sfr(1'b1, 8'ha2, 8'h02);
    do_fetch(8'h02, 1'b0);
    check("short miss fill", {15'h0000, seen.write}, 16'h0000);
    do_fetch(8'h03, 1'b0);
    check("long miss fill", {15'h0000, seen.write}, 16'h0001);
    sfr(1'b1, 8'ha2, 8'h04);
    do_fetch(8'h01, 1'b1);
    check("forced slot", {8'h00, seen}, 16'h0080);
    sfr(1'b1, 8'ha3, 8'h80);
    do_fetch(8'h01, 1'b1);
    check("push one", {8'h00, seen}, 16'h00ff);
    do_fetch(8'h01, 1'b1);
    check("push two", {8'h00, seen}, 16'h00fe);
    check("pointer after push", {10'h000, ptr}, 16'h003d);
    sfr(1'b0, 8'ha3, 8'hbd);
    sfr(1'b1, 8'ha3, 8'h40);
    check("pointer after pop", {10'h000, ptr}, 16'h003e);
    sfr(1'b0, 8'ha3, 8'h3e);
    sfr(1'b1, 8'ha2, 8'h08);
    for (int i = 0; i < 8; i++) begin
      do_fetch(8'h01, 1'b0);
      check("random in range", {14'h0000, seen.write, seen.slot <= 6'h3e}, 16'h0003);
    end
    flash_busy_in = 1'b1;
    sfr(1'b0, 8'h88, 8'h01);
    flash_busy_in = 1'b0;
    flash_addr_in = 16'h1234;
    flash_modify_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
    flash_modify_in = 1'b0;
    check("invalidate", {inval_addr[14:0], inval}, 16'h2469);
    sfr(1'b1, 8'h9a, 8'h01);
    do_fetch(8'h09, 1'b0);
    sfr(1'b0, 8'h9a, 8'h01);
    sfr(1'b0, 8'ha2, 8'h48);
    sfr(1'b1, 8'h9a, 8'h7f);
    do_fetch(8'h21, 1'b0);
    sfr(1'b0, 8'h9a, 8'h80);
    do_fetch(8'h01, 1'b0);
    sfr(1'b0, 8'h9a, 8'h80);
    sfr(1'b1, 8'h9a, 8'h00);
    sfr(1'b0, 8'h9a, 8'h00);
    rst_n_in = 1'b0;
    @(posedge sys_clk_in);
    #1;
    rst_n_in = 1'b1;
    check("pointer after reset", {10'h000, ptr}, 16'h003f);
    sfr(1'b0, 8'ha3, 8'h3f);
    sfr(1'b0, 8'ha2, 8'h04);
    give_verdict();
  end
endmodule
